/* hw/agu_pkg.sv */
package agu_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] X_START_OFS = 8'h00;
   localparam logic [7:0] X_END_OFS = 8'h04;
   localparam logic [7:0] Y_START_OFS = 8'h08;
   localparam logic [7:0] Y_END_OFS = 8'h0c;
   localparam logic [7:0] MODE_CTRL_OFS = 8'h10;
   localparam logic [7:0] PIVOT_CTRL_OFS = 8'h14;
   localparam logic [7:0] STATUS_OFS = 8'h18;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int X_SEL_LSB = 0;
   localparam int Y_SEL_LSB = 4;
   localparam int B_SEL_LSB = 8;
   localparam int Y_EN_BIT = 14;
   localparam int X_EN_BIT = 15;
   localparam int B_EN_BIT = 15;
   localparam int ST_WRAP_BIT = 16;
   localparam int ST_BREV_BIT = 17;
   localparam int ST_ILLEGAL_BIT = 18;

   // ---------------------------------------------------------------
   // Reset values and codes
   // ---------------------------------------------------------------
   localparam logic [15:0] MODE_CTRL_RST = 16'h0fff;
   localparam logic [15:0] PIVOT_CTRL_RST = 16'h0000;
   localparam logic [15:0] BOUND_RST = 16'h0000;
   localparam logic [3:0] SEL_NONE = 4'hf;
   localparam logic [3:0] STACK_PTR = 4'hf;
   localparam logic [3:0] DSP_X_LO = 4'h8;
   localparam logic [3:0] DSP_X_IX = 4'h9;
   localparam logic [3:0] DSP_Y_LO = 4'ha;
   localparam logic [3:0] DSP_Y_IX = 4'hb;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      AM_INDIRECT = 2'h0,
      AM_POST = 2'h1,
      AM_PRE = 2'h2,
      AM_INDEXED = 2'h3
   } addr_mode_t;

endpackage

/* hw/circular_wrap.sv */
`timescale 1ns/100ps
`default_nettype none
module circular_wrap #(
   parameter int W = 16
) (
   input wire logic enable,
   input wire logic up,
   input wire logic word_only,
   input wire logic [W-1:0] start_addr,
   input wire logic [W-1:0] end_addr,
   input wire logic [W-1:0] next_addr,
   output logic [W-1:0] corrected,
   output logic wrapped
);

   logic [W:0] len;
   logic [W-1:0] fixed;

   always_comb begin
      // R6: length from bounds
      // R22: one word past end
      len = {1'b0, end_addr} - {1'b0, start_addr} + {{(W-1){1'b0}}, 2'b10};
      fixed = next_addr;
      wrapped = 1'b0;
      // R10: beyond bound, not only equal
      // R5: both boundaries checked
      if (enable && up && next_addr > end_addr) begin
         fixed = next_addr - len[W-1:0];
         wrapped = 1'b1;
      end else if (enable && !up && next_addr < start_addr) begin
         fixed = next_addr + len[W-1:0];
         wrapped = 1'b1;
      end
      corrected = fixed;
      // R7: y space word aligned
      if (enable && word_only) begin
         corrected[0] = 1'b0;
      end
   end

endmodule
`default_nettype wire

/* hw/dsp_address_generation_unit.sv */
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
//Contract
// R1: Dual-source pointers W8-W11, split X/Y
// R2: Dual-source indexed only W9 and W11
// R3: Dual-source modes indirect, post 2/4/6, indexed
// R4: One circular buffer per space, any pointer
// R5: Power-of-two buffers checked at both bounds
// R6: Length from 16-bit start and end
// R7: Y circular addresses keep LSB clear
// R8: X circular needs select not 1111, bit15
// R9: Y circular needs select not 1111, bit14
// R10: Crossing past bound still wraps correctly
// R11: Write back only for pre/post modify
// R12: Bit reversal X space writes only
// R13: Only modifier bit order is reversed
// R14: Bit reversal enables; never stack pointer
// R15: Software aligns bit-reversed buffer start
// R16: 15-bit pivot scaled to bytes
// R17: Bit reversal only word pre/post increment
// R18: Pivot replaces mode offset, LSB clear
// R19: Bit reversal beats circular on writes
// R20: Software avoids read after pivot rewrite
// R21: Index maps to its bit mirror
// R22: Wrap subtracts or adds buffer length
module dsp_address_generation_unit
   import agu_pkg::*;
#(
   parameter int AW = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic req_valid,
   input wire logic req_dsp,
   input wire logic [3:0] req_ptr,
   input wire logic [AW-1:0] req_ptr_value,
   input wire logic [1:0] req_mode,
   input wire logic [AW-1:0] req_modifier,
   input wire logic req_write,
   input wire logic req_byte,
   input wire logic req_y_space,
   output logic rsp_valid,
   output logic [AW-1:0] rsp_addr,
   output logic rsp_y_space,
   output logic rsp_wb_en,
   output logic [AW-1:0] rsp_wb_value,
   output logic rsp_illegal
);

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [15:0] x_circular_buffer_start_r;
   logic [15:0] x_circular_buffer_end_r;
   logic [15:0] y_circular_buffer_start_r;
   logic [15:0] y_circular_buffer_end_r;
   logic [15:0] addressing_mode_control_r;
   logic [15:0] bit_reverse_pivot_control_r;
   logic [15:0] last_addr_r;
   logic last_wrap_r;
   logic last_brev_r;
   logic last_illegal_r;

   logic aw_got_r;
   logic w_got_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;

   logic do_write;
   logic write_hit;

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   assign do_write = aw_got_r && w_got_r && !bvalid_r;
   assign write_hit = aw_addr_r <= STATUS_OFS && aw_addr_r[1:0] == 2'b00;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [15:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Write channels
   // ---------------------------------------------------------------
   // Address and data taken in either order; answer follows both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            aw_got_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            awready_r <= 1'b0;
         end
         if (s_axi_wvalid && wready_r) begin
            w_got_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            wready_r <= 1'b0;
         end
         if (do_write) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= write_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         x_circular_buffer_start_r <= BOUND_RST;
         x_circular_buffer_end_r <= BOUND_RST;
         y_circular_buffer_start_r <= BOUND_RST;
         y_circular_buffer_end_r <= BOUND_RST;
         addressing_mode_control_r <= MODE_CTRL_RST;
         bit_reverse_pivot_control_r <= PIVOT_CTRL_RST;
      end else if (do_write) begin
         case (aw_addr_r)
            X_START_OFS: begin
               x_circular_buffer_start_r <= merge(x_circular_buffer_start_r, w_data_r, w_strb_r);
            end
            X_END_OFS: begin
               x_circular_buffer_end_r <= merge(x_circular_buffer_end_r, w_data_r, w_strb_r);
            end
            Y_START_OFS: begin
               y_circular_buffer_start_r <= merge(y_circular_buffer_start_r, w_data_r, w_strb_r);
            end
            Y_END_OFS: begin
               y_circular_buffer_end_r <= merge(y_circular_buffer_end_r, w_data_r, w_strb_r);
            end
            MODE_CTRL_OFS: begin
               addressing_mode_control_r <= merge(addressing_mode_control_r, w_data_r, w_strb_r);
            end
            PIVOT_CTRL_OFS: begin
               bit_reverse_pivot_control_r <= merge(bit_reverse_pivot_control_r, w_data_r, w_strb_r);
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            case (s_axi_araddr)
               X_START_OFS: rdata_r <= {16'h0000, x_circular_buffer_start_r};
               X_END_OFS: rdata_r <= {16'h0000, x_circular_buffer_end_r};
               Y_START_OFS: rdata_r <= {16'h0000, y_circular_buffer_start_r};
               Y_END_OFS: rdata_r <= {16'h0000, y_circular_buffer_end_r};
               MODE_CTRL_OFS: rdata_r <= {16'h0000, addressing_mode_control_r};
               PIVOT_CTRL_OFS: rdata_r <= {16'h0000, bit_reverse_pivot_control_r};
               STATUS_OFS: rdata_r <= {13'h0000, last_illegal_r, last_brev_r, last_wrap_r, last_addr_r};
               default: begin
                  rdata_r <= 32'h0000_0000;
                  rresp_r <= RESP_SLVERR;
               end
            endcase
         end
         if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Address calculation
   // ---------------------------------------------------------------
   logic [3:0] x_sel;
   logic [3:0] y_sel;
   logic [3:0] b_sel;
   logic x_space;
   logic up;
   logic modifies;
   logic illegal;
   logic x_circ_on;
   logic y_circ_on;
   logic brev_on;
   logic [AW-1:0] sum;
   logic [AW-1:0] mag;
   logic [AW-1:0] brev_next;
   logic [AW-1:0] x_fixed;
   logic [AW-1:0] y_fixed;
   logic x_wrapped;
   logic y_wrapped;
   logic [AW-1:0] new_ptr;
   logic [AW-1:0] ea;
   logic wrapped;

   function automatic logic [AW-1:0] mirror(input logic [AW-1:0] v);
      logic [AW-1:0] r;
      r = '0;
      for (int i = 0; i < AW; i++) begin
         r[i] = v[AW-1-i];
      end
      return r;
   endfunction

   assign x_sel = addressing_mode_control_r[X_SEL_LSB +: 4];
   assign y_sel = addressing_mode_control_r[Y_SEL_LSB +: 4];
   assign b_sel = addressing_mode_control_r[B_SEL_LSB +: 4];

   always_comb begin
      // R1: W8/W9 to X, W10/W11 to Y
      x_space = req_dsp ? (req_ptr == DSP_X_LO || req_ptr == DSP_X_IX) : !req_y_space;
      up = !req_modifier[AW-1];
      mag = up ? req_modifier : AW'(-req_modifier);
      modifies = req_mode == AM_PRE || req_mode == AM_POST;
      illegal = 1'b0;
      if (req_dsp) begin
         // R1: only W8 through W11
         if (req_ptr < DSP_X_LO || req_ptr > DSP_Y_IX) begin
            illegal = 1'b1;
         end
         // R2: indexed through W9 or W11
         if (req_mode == AM_INDEXED && req_ptr != DSP_X_IX && req_ptr != DSP_Y_IX) begin
            illegal = 1'b1;
         end
         // R3: no pre-modify, post by 2/4/6
         if (req_mode == AM_PRE) begin
            illegal = 1'b1;
         end
         if (req_mode == AM_POST && mag != AW'(2) && mag != AW'(4) && mag != AW'(6)) begin
            illegal = 1'b1;
         end
      end
      sum = req_ptr_value + req_modifier;
      // R4: one select field per space
      // R8: x select and enable
      x_circ_on = addressing_mode_control_r[X_EN_BIT] && x_sel != SEL_NONE && req_ptr == x_sel && x_space;
      // R9: y select and enable
      y_circ_on = addressing_mode_control_r[Y_EN_BIT] && y_sel != SEL_NONE && req_ptr == y_sel && !x_space;
      // R14: enables, never stack pointer
      // R12: x space writes only
      // R17: word pre/post increment only
      brev_on = bit_reverse_pivot_control_r[B_EN_BIT] && b_sel != SEL_NONE && req_ptr == b_sel
         && req_ptr != STACK_PTR && x_space && req_write && !req_byte && modifies && up;
      // R13: only modifier mirrored
      // R16: pivot scaled to bytes
      // R18: pivot replaces mode offset
      // R21: bit-mirrored carry path
      brev_next = mirror(mirror(req_ptr_value) + mirror({bit_reverse_pivot_control_r[14:0], 1'b0}));
      brev_next[0] = 1'b0;
   end

   circular_wrap #(
      .W(AW)
   ) u_x_wrap (
      .enable(x_circ_on && req_mode != AM_INDIRECT),
      .up(up),
      .word_only(1'b0),
      .start_addr(x_circular_buffer_start_r),
      .end_addr(x_circular_buffer_end_r),
      .next_addr(sum),
      .corrected(x_fixed),
      .wrapped(x_wrapped)
   );

   // R7: y space word sized
   circular_wrap #(
      .W(AW)
   ) u_y_wrap (
      .enable(y_circ_on && req_mode != AM_INDIRECT),
      .up(up),
      .word_only(1'b1),
      .start_addr(y_circular_buffer_start_r),
      .end_addr(y_circular_buffer_end_r),
      .next_addr(sum),
      .corrected(y_fixed),
      .wrapped(y_wrapped)
   );

   always_comb begin
      wrapped = x_space ? x_wrapped : y_wrapped;
      new_ptr = x_space ? x_fixed : y_fixed;
      // R19: bit reversal wins on writes
      if (brev_on) begin
         new_ptr = brev_next;
         wrapped = 1'b0;
      end
      case (req_mode)
         AM_PRE: ea = new_ptr;
         AM_INDEXED: ea = new_ptr;
         default: ea = req_ptr_value;
      endcase
   end

   // ---------------------------------------------------------------
   // Response
   // ---------------------------------------------------------------
   // Registered so decode sees a fixed one-cycle answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rsp_valid <= 1'b0;
         rsp_addr <= '0;
         rsp_y_space <= 1'b0;
         rsp_wb_en <= 1'b0;
         rsp_wb_value <= '0;
         rsp_illegal <= 1'b0;
      end else begin
         rsp_valid <= req_valid;
         rsp_addr <= ea;
         rsp_y_space <= !x_space;
         // R11: pointer kept for indexed
         rsp_wb_en <= req_valid && modifies && !illegal;
         rsp_wb_value <= new_ptr;
         rsp_illegal <= req_valid && illegal;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_addr_r <= 16'h0000;
         last_wrap_r <= 1'b0;
         last_brev_r <= 1'b0;
         last_illegal_r <= 1'b0;
      end else if (req_valid) begin
         last_addr_r <= ea;
         last_wrap_r <= wrapped;
         last_brev_r <= brev_on;
         last_illegal_r <= illegal;
      end
   end

endmodule
`default_nettype wire

/* verification/agu_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module agu_monitor
   import agu_pkg::*;
#(
   parameter int AW = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic req_valid,
   input wire logic req_dsp,
   input wire logic [3:0] req_ptr,
   input wire logic [AW-1:0] req_ptr_value,
   input wire logic [1:0] req_mode,
   input wire logic rsp_valid,
   input wire logic [AW-1:0] rsp_addr,
   input wire logic rsp_y_space,
   input wire logic rsp_wb_en,
   input wire logic rsp_illegal
);
   // ------
   // Checks
   // ------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_rsp_follows: assert property (req_valid |=> rsp_valid) else $error("response missing");
   a_rsp_quiet: assert property (!req_valid |=> !rsp_valid) else $error("response without request");
   a_index_nowb: assert property (req_valid && req_mode == AM_INDEXED |=> !rsp_wb_en) else $error("indexed wb");
   a_plain_nowb: assert property (req_valid && req_mode == AM_INDIRECT |=> !rsp_wb_en) else $error("plain wb");
   a_dsp_range: assert property (req_valid && req_dsp && (req_ptr < DSP_X_LO || req_ptr > DSP_Y_IX)
      |=> rsp_illegal) else $error("dsp pointer not flagged");
   a_dsp_route: assert property (req_valid && req_dsp && req_ptr[3:2] == 2'h2
      |=> rsp_y_space == $past(req_ptr[1])) else $error("dsp space wrong");
   a_dsp_index: assert property (req_valid && req_dsp && req_mode == AM_INDEXED && req_ptr != DSP_X_IX
      && req_ptr != DSP_Y_IX |=> rsp_illegal) else $error("dsp index not flagged");
   a_plain_ea: assert property (req_valid && !req_dsp && req_mode == AM_INDIRECT
      |=> rsp_addr == $past(req_ptr_value)) else $error("plain address wrong");
   a_illegal_nowb: assert property (rsp_illegal |-> !rsp_wb_en) else $error("illegal with wb");
endmodule
bind dsp_address_generation_unit agu_monitor #(.AW(AW)) mon (
   .aclk(aclk), .aresetn(aresetn), .req_valid(req_valid), .req_dsp(req_dsp), .req_ptr(req_ptr),
   .req_ptr_value(req_ptr_value), .req_mode(req_mode), .rsp_valid(rsp_valid), .rsp_addr(rsp_addr),
   .rsp_y_space(rsp_y_space), .rsp_wb_en(rsp_wb_en), .rsp_illegal(rsp_illegal)
);
`default_nettype wire

/* verification/decode_model.sv */
`timescale 1ns/100ps
`default_nettype none
module decode_model
   import agu_pkg::*;
(
   input wire logic aclk,
   output logic req_valid,
   output logic req_dsp,
   output logic [3:0] req_ptr,
   output logic [15:0] req_ptr_value,
   output logic [1:0] req_mode,
   output logic [15:0] req_modifier,
   output logic req_write,
   output logic req_byte,
   output logic req_y_space
);
   // ------------
   // Decode stage
   // ------------
   initial begin
      req_valid = 1'h0;
      req_dsp = 1'h0;
      req_ptr = 4'h0;
      req_ptr_value = 16'h0000;
      req_mode = 2'h0;
      req_modifier = 16'h0000;
      req_write = 1'h0;
      req_byte = 1'h0;
      req_y_space = 1'h0;
   end
   task automatic issue(input logic d, input logic [3:0] p, input logic [15:0] v, input addr_mode_t m,
      input logic [15:0] md, input logic w, input logic b, input logic y);
      @(posedge aclk);
      req_valid <= 1'h1;
      req_dsp <= d;
      req_ptr <= p;
      req_ptr_value <= v;
      req_mode <= m;
      req_modifier <= md;
      req_write <= w;
      req_byte <= b;
      req_y_space <= y;
      @(posedge aclk);
      req_valid <= 1'h0;
      // Stale operands inverted so no leftover value can pass
      req_ptr_value <= ~v;
      req_modifier <= ~md;
      #1;
   endtask
endmodule
`default_nettype wire

/* verification/test_dsp_address_generation_unit.sv */
`timescale 1ns/100ps
`default_nettype none
module test_dsp_address_generation_unit
   import agu_pkg::*;
;
   localparam logic lo = 1'h0;
   localparam logic hi = 1'h1;
   logic aclk, aresetn, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
   logic [7:0] awa, ara;
   logic [31:0] wd, rd;
   logic [1:0] bresp, rresp, rq_m;
   logic rq_v, rq_d, rq_w, rq_b, rq_y, rs_v, rs_y, rs_wb, rs_ill;
   logic [3:0] rq_p;
   logic [15:0] rq_pv, rq_md, rs_a, rs_wbv;
   int fail_count, n_tests;
   // -----------
   // Environment
   // -----------
   dsp_address_generation_unit #(.AW(16)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .req_valid(rq_v),
      .req_dsp(rq_d), .req_ptr(rq_p), .req_ptr_value(rq_pv), .req_mode(rq_m), .req_modifier(rq_md),
      .req_write(rq_w), .req_byte(rq_b), .req_y_space(rq_y), .rsp_valid(rs_v), .rsp_addr(rs_a),
      .rsp_y_space(rs_y), .rsp_wb_en(rs_wb), .rsp_wb_value(rs_wbv), .rsp_illegal(rs_ill));
   decode_model cpu (.aclk(aclk), .req_valid(rq_v), .req_dsp(rq_d), .req_ptr(rq_p), .req_ptr_value(rq_pv),
      .req_mode(rq_m), .req_modifier(rq_md), .req_write(rq_w), .req_byte(rq_b), .req_y_space(rq_y));
   initial begin
      {aclk, aresetn, awv, wv, br, arv, rr, awa, ara, wd} = '0;
      fail_count = 0;
      n_tests = 0;
   end
   always #10 aclk = ~aclk;
   // -----
   // Tasks
   // -----
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Waits as long as the slave needs; only the watchdog ends a hang
   task automatic axi_w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= hi;
      wv <= hi;
      br <= hi;
      do begin
         @(posedge aclk);
         if (awr) awv <= lo;
         if (wrd) wv <= lo;
      end while (!bv);
      br <= lo;
      chk(bresp, er);
   endtask
   task automatic axi_r(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      ara <= a;
      arv <= hi;
      rr <= hi;
      do begin
         @(posedge aclk);
         if (arr) arv <= lo;
      end while (!rv);
      rr <= lo;
      chk(rd, ed);
      chk(rresp, er);
   endtask
   task automatic req(input logic d, input logic [3:0] p, input logic [15:0] v, input addr_mode_t m,
      input logic [15:0] md, input logic w, input logic b, input logic y, input logic [15:0] ea,
      input logic we, input logic [15:0] wb, input logic il);
      cpu.issue(d, p, v, m, md, w, b, y);
      chk(rs_v, hi);
      if (!il) chk(rs_a, ea);
      chk(rs_wb, we);
      if (we) chk(rs_wbv, wb);
      chk(rs_ill, il);
   endtask
   // ---------
   // Scenarios
   // ---------
   task automatic test_regs;
      axi_r(MODE_CTRL_OFS, 32'h0000_0fff, RESP_OKAY);
      axi_r(PIVOT_CTRL_OFS, 32'h0000_0000, RESP_OKAY);
      axi_w(Y_END_OFS, 32'hdead_2006, RESP_OKAY);
      axi_r(Y_END_OFS, 32'h0000_2006, RESP_OKAY);
      axi_r(8'h1c, 32'h0000_0000, RESP_SLVERR);
      $display("test regs done");
   endtask
   task automatic test_circ;
      axi_w(X_START_OFS, 32'h0000_1000, RESP_OKAY);
      axi_w(X_END_OFS, 32'h0000_100e, RESP_OKAY);
      axi_w(MODE_CTRL_OFS, 32'h0000_8ff2, RESP_OKAY);
      req(lo, 4'h2, 16'h100e, AM_POST, 16'h0002, lo, lo, lo, 16'h100e, hi, 16'h1000, lo);
      axi_r(STATUS_OFS, 32'h0001_100e, RESP_OKAY);
      req(lo, 4'h2, 16'h100e, AM_INDIRECT, 16'h0002, lo, lo, lo, 16'h100e, lo, 16'h0000, lo);
      req(lo, 4'h2, 16'h100c, AM_PRE, 16'h0006, lo, lo, lo, 16'h1002, hi, 16'h1002, lo);
      req(lo, 4'h2, 16'h1000, AM_POST, 16'hfffe, lo, lo, lo, 16'h1000, hi, 16'h100e, lo);
      req(lo, 4'h2, 16'h100a, AM_INDEXED, 16'h0008, lo, lo, lo, 16'h1002, lo, 16'h0000, lo);
      req(lo, 4'h3, 16'h100e, AM_POST, 16'h0002, lo, lo, lo, 16'h100e, hi, 16'h1010, lo);
      axi_w(MODE_CTRL_OFS, 32'h0000_0ff2, RESP_OKAY);
      req(lo, 4'h2, 16'h100e, AM_POST, 16'h0002, lo, lo, lo, 16'h100e, hi, 16'h1010, lo);
      axi_w(Y_START_OFS, 32'h0000_2000, RESP_OKAY);
      axi_w(MODE_CTRL_OFS, 32'h0000_4f2f, RESP_OKAY);
      req(lo, 4'h2, 16'h2006, AM_POST, 16'h0002, lo, lo, hi, 16'h2006, hi, 16'h2000, lo);
      req(lo, 4'h2, 16'h2001, AM_PRE, 16'h0002, lo, lo, hi, 16'h2002, hi, 16'h2002, lo);
      $display("test circ done");
   endtask
   // Buffer starts at zero, so its low bits are clear
   task automatic test_brev;
      axi_w(PIVOT_CTRL_OFS, 32'h0000_8008, RESP_OKAY);
      // no read via pointer after pivot write
      axi_w(MODE_CTRL_OFS, 32'h0000_04ff, RESP_OKAY);
      req(lo, 4'h4, 16'h0000, AM_POST, 16'h0002, hi, lo, lo, 16'h0000, hi, 16'h0010, lo);
      req(lo, 4'h4, 16'h0010, AM_POST, 16'h0002, hi, lo, lo, 16'h0010, hi, 16'h0008, lo);
      req(lo, 4'h4, 16'h0008, AM_PRE, 16'h0002, hi, lo, lo, 16'h0018, hi, 16'h0018, lo);
      req(lo, 4'h4, 16'h0008, AM_POST, 16'h0002, hi, hi, lo, 16'h0008, hi, 16'h000a, lo);
      req(lo, 4'h4, 16'h0008, AM_POST, 16'h0002, lo, lo, lo, 16'h0008, hi, 16'h000a, lo);
      axi_w(MODE_CTRL_OFS, 32'h0000_84f4, RESP_OKAY);
      req(lo, 4'h4, 16'h100e, AM_POST, 16'h0002, hi, lo, lo, 16'h100e, hi, 16'h101e, lo);
      req(lo, 4'h5, 16'h0008, AM_POST, 16'h0002, hi, lo, lo, 16'h0008, hi, 16'h000a, lo);
      $display("test brev done");
   endtask
   task automatic test_dsp;
      axi_w(MODE_CTRL_OFS, 32'h0000_0fff, RESP_OKAY);
      req(hi, 4'h7, 16'h0100, AM_INDIRECT, 16'h0000, lo, lo, lo, 16'h0000, lo, 16'h0000, hi);
      req(hi, 4'h8, 16'h0100, AM_INDEXED, 16'h0004, lo, lo, lo, 16'h0000, lo, 16'h0000, hi);
      req(hi, 4'h9, 16'h0100, AM_INDEXED, 16'h0004, lo, lo, lo, 16'h0104, lo, 16'h0000, lo);
      chk(rs_y, lo);
      req(hi, 4'ha, 16'h0200, AM_POST, 16'h0004, lo, lo, lo, 16'h0200, hi, 16'h0204, lo);
      chk(rs_y, hi);
      req(hi, 4'hb, 16'h0200, AM_POST, 16'hfffa, lo, lo, lo, 16'h0200, hi, 16'h01fa, lo);
      req(hi, 4'h8, 16'h0300, AM_POST, 16'h0008, lo, lo, lo, 16'h0000, lo, 16'h0000, hi);
      axi_r(STATUS_OFS, 32'h0004_0300, RESP_OKAY);
      axi_w(STATUS_OFS, 32'h0000_ffff, RESP_OKAY);
      axi_r(STATUS_OFS, 32'h0004_0300, RESP_OKAY);
      axi_w(8'h1c, 32'h0000_ffff, RESP_SLVERR);
      $display("test dsp done");
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ----
   // Main
   // ----
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= hi;
      test_regs();
      test_circ();
      test_brev();
      test_dsp();
      conclude();
   end
   initial begin
      #200000;
      fail_count++;
      conclude();
   end
endmodule
`default_nettype wire
